// ===== tb_timer_wdt_ir_pulse_gen.sv
module tb_timer_wdt_ir_pulse_gen;
    timeunit 1ns;
    timeprecision 1ps;
    import twp_pkg::*;
    logic clk = 1'b0, rst = 1'b1, divOpt = 1'b0, wdShort = 1'b0, convAct = 1'b0;
    logic convWake = 1'b0, wdTick = 1'b0, tPin = 1'b0, pulse, lowIrq, highIrq, wdRst, g;
    logic [7:0] awAddr = 8'h00, arAddr = 8'h00, t0;
    logic [31:0] wData = 32'h0000_0000, rData, rv;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [1:0] bResp, rResp, rr, wResp;
    logic [3:0] wStrb = 4'hF;
    int nFail = 0, totalChecks = 0, a, b, i;
    // pulse rows: scale ctrl, low width, high width (low=2, high=1, tick=clk)
    logic [7:0] scRow [6] = '{8'h00, 8'h08, 8'h0B, 8'h80, 8'hF0, 8'h0F};
    int loRow [6] = '{3, 6, 48, 3, 3, 768};
    int hiRow [6] = '{2, 2, 2, 4, 512, 2};

    always #12.5 clk = ~clk;

    twp_timer #(.WD_LONG(4), .WD_SHORT(2)) twp_timer_i (.clk(clk), .rst(rst),
        .clock_div_option(divOpt), .wd_short_option(wdShort), .conversion_active(convAct),
        .conversion_wake_en(convWake), .wd_osc_tick(wdTick), .timer_pin(tPin),
        .pulse_out_pin(pulse), .low_irq(lowIrq), .high_irq(highIrq), .watchdog_reset(wdRst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));

    task automatic endOfTest;
        $display("checks %0d mismatches %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : endOfTest

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        int k;
        awAddr <= ad;
        wData <= {24'h00_0000, d};
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
            if (bValid) break;
        end
        wResp = bResp;
        bReady <= 1'b0;
        if (k == 50) begin
            nFail++;
            endOfTest();
        end
    endtask : wr

    task automatic rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
        int k;
        arAddr <= ad;
        arValid <= 1'b1;
        rReady <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (arReady) arValid <= 1'b0;
            if (rValid) break;
        end
        d = rData;
        r = rResp;
        rReady <= 1'b0;
        if (k == 50) begin
            nFail++;
            endOfTest();
        end
    endtask : rd

    task automatic rdc(input logic [7:0] ad, input logic [7:0] exp);
        rd(ad, rv, rr);
        chk(rv, {24'h00_0000, exp});
    endtask : rdc

    // bounded: a stuck pin ends the run as a mismatch
    task automatic seg(input logic lvl, output int cnt);
        cnt = 0;
        while (pulse === lvl && cnt < 3000) begin
            @(posedge clk);
            cnt++;
        end
        if (cnt == 3000) begin
            nFail++;
            endOfTest();
        end
    endtask : seg

    // skips a partial period first, the phase after a write is unknown
    task automatic period(output int lo, output int hi);
        seg(1'b0, lo);
        seg(1'b1, lo);
        seg(1'b0, lo);
        seg(1'b1, hi);
    endtask : period

    task automatic ticks(input int cnt, output logic got);
        got = 1'b0;
        repeat (cnt) begin
            wdTick <= 1'b1;
            @(posedge clk);
            wdTick <= 1'b0;
            repeat (4) begin
                @(posedge clk);
                got = got | wdRst;
            end
        end
    endtask : ticks

    // two reads 40 cycles apart, both sample at the same point of the read
    task automatic rate(input logic [7:0] exp);
        rd(OFF_TIMER, rv, rr);
        t0 = rv[7:0];
        repeat (38) @(posedge clk);
        rd(OFF_TIMER, rv, rr);
        t0 = rv[7:0] - t0;
        chk({24'h00_0000, t0}, {24'h00_0000, exp});
    endtask : rate

    task automatic pins(input int cnt);
        repeat (cnt) begin
            tPin <= 1'b1;
            repeat (8) @(posedge clk);
            tPin <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask : pins

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(32'(pulse), 32'h0000_0001);
        rdc(OFF_TIMER_CTRL, TIMER_CTRL_RESET);
        wr(OFF_PRESCALE, 8'hA5);
        rdc(OFF_PRESCALE, 8'hA5);
        wr(OFF_TIMER, 8'h00);
        rdc(OFF_PRESCALE, 8'h00);
        wr(OFF_PRESCALE, 8'hA5);
        wr(OFF_TIMER_CTRL, 8'h3F);
        rdc(OFF_PRESCALE, 8'h00);
        rd(8'h30, rv, rr);
        chk(32'(rr), 32'(RESP_SLVERR));
        chk(rv, 32'h0000_0000);
        wr(8'h30, 8'h11);
        chk(32'(wResp), 32'(RESP_SLVERR));
        wStrb <= 4'h0;
        wr(OFF_LOW_TIME, 8'h55);
        wStrb <= 4'hF;
        chk(32'(wResp), 32'(RESP_OKAY));
        rdc(OFF_LOW_TIME, CTRL_RESET);
        $display("done: prescaler and map");
        wr(OFF_LOW_TIME, 8'h02);
        wr(OFF_HIGH_TIME, 8'h01);
        wr(OFF_CARRIER_CTRL, 8'hD0);
        for (i = 0; i < 6; i++) begin
            wr(OFF_SCALE, scRow[i]);
            period(a, b);
            chk(a, loRow[i]);
            chk(b, hiRow[i]);
        end
        rdc(OFF_SCALE, 8'h0F);
        chk(32'(lowIrq), 32'h0000_0001);
        chk(32'(highIrq), 32'h0000_0001);
        wr(OFF_CARRIER_CTRL, 8'hC0);
        wr(OFF_CMD, 8'h18);
        chk(32'({lowIrq, highIrq}), 32'h0000_0000);
        $display("done: pulse widths");
        wr(OFF_HIGH_TIME, 8'hFF);
        wr(OFF_LOW_TIME, 8'h20);
        wr(OFF_SCALE, 8'h00);
        wr(OFF_CARRIER, 8'h01);
        for (i = 0; i < 2; i++) begin
            divOpt <= i[0];
            wr(OFF_CARRIER_CTRL, 8'h30);
            b = 0;
            for (a = 0; a < 20 && b < 100; a++) begin
                seg(1'b0, b);
                seg(1'b1, b);
            end
            if (b < 100) begin
                nFail++;
                endOfTest();
            end
            period(a, b);
            chk(a, 2 * (1 + i));
            chk(b, 2 * (1 + i));
            wr(OFF_CARRIER_CTRL, 8'h00);
        end
        divOpt <= 1'b0;
        $display("done: carrier");
        wr(OFF_TIMER_CTRL, 8'h20);
        wr(OFF_TIMER, 8'h00);
        pins(5);
        rdc(OFF_TIMER, 8'h05);
        wr(OFF_TIMER_CTRL, 8'h30);
        wr(OFF_TIMER, 8'h00);
        pins(3);
        rdc(OFF_TIMER, 8'h03);
        wr(OFF_TIMER_CTRL, 8'h00);
        rate(8'h14);
        divOpt <= 1'b1;
        rate(8'h0A);
        divOpt <= 1'b0;
        wr(OFF_CMD, 8'h02);
        rate(8'h00);
        convAct <= 1'b1;
        convWake <= 1'b1;
        rate(8'h14);
        wr(OFF_CMD, 8'h04);
        convAct <= 1'b0;
        convWake <= 1'b0;
        $display("done: main timer");
        wr(OFF_WDOG_CTRL, 8'h80);
        ticks(3, g);
        chk(32'(g), 32'h0000_0000);
        ticks(2, g);
        chk(32'(g), 32'h0000_0001);
        rd(OFF_STATUS, rv, rr);
        chk(32'(rv[ST_WD_RESET]), 32'h0000_0001);
        rdc(OFF_WDOG_CTRL, CTRL_RESET);
        wdShort <= 1'b1;
        wr(OFF_WDOG_CTRL, 8'h80);
        ticks(1, g);
        chk(32'(g), 32'h0000_0000);
        ticks(2, g);
        chk(32'(g), 32'h0000_0001);
        wdShort <= 1'b0;
        wr(OFF_WDOG_CTRL, 8'h80);
        ticks(3, g);
        wr(OFF_CMD, 8'h01);
        ticks(3, g);
        chk(32'(g), 32'h0000_0000);
        wr(OFF_CMD, 8'h02);
        ticks(3, g);
        chk(32'(g), 32'h0000_0000);
        ticks(2, g);
        chk(32'(g), 32'h0000_0001);
        wr(OFF_WDOG_CTRL, 8'h80);
        ticks(3, g);
        wr(OFF_WDOG_CTRL, 8'h00);
        ticks(6, g);
        chk(32'(g), 32'h0000_0000);
        wr(OFF_CMD, 8'h01);
        wr(OFF_WDOG_CTRL, 8'h88);
        ticks(7, g);
        chk(32'(g), 32'h0000_0000);
        ticks(3, g);
        chk(32'(g), 32'h0000_0001);
        $display("done: watchdog");
        endOfTest();
    end
endmodule : tb_timer_wdt_ir_pulse_gen

// ===== twp_pkg.sv
package twp_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_LOW_TIME = 8'h00;
    localparam logic [7:0] OFF_HIGH_TIME = 8'h04;
    localparam logic [7:0] OFF_SCALE = 8'h08;
    localparam logic [7:0] OFF_PRESCALE = 8'h0C;
    localparam logic [7:0] OFF_TIMER = 8'h10;
    localparam logic [7:0] OFF_TIMER_CTRL = 8'h14;
    localparam logic [7:0] OFF_CARRIER = 8'h18;
    localparam logic [7:0] OFF_CARRIER_CTRL = 8'h1C;
    localparam logic [7:0] OFF_WDOG_CTRL = 8'h20;
    localparam logic [7:0] OFF_CMD = 8'h24;
    localparam logic [7:0] OFF_STATUS = 8'h28;
    // scale control fields
    localparam int HIGH_EN_BIT = 7;
    localparam int HIGH_SEL_LSB = 4;
    localparam int LOW_EN_BIT = 3;
    localparam int LOW_SEL_LSB = 0;
    // timer control fields
    localparam int TMR_RATIO_LSB = 0;
    localparam int TMR_PRE_EN_BIT = 3;
    localparam int TMR_EDGE_BIT = 4;
    localparam int TMR_SRC_BIT = 5;
    // carrier control fields
    localparam int CAR_RATIO_LSB = 0;
    localparam int CAR_PRE_EN_BIT = 3;
    localparam int PULSE_EN_BIT = 4;
    localparam int CARRIER_EN_BIT = 5;
    localparam int LOW_IE_BIT = 6;
    localparam int HIGH_IE_BIT = 7;
    // watchdog control fields
    localparam int WD_RATIO_LSB = 0;
    localparam int WD_PRE_EN_BIT = 3;
    localparam int WD_EN_BIT = 7;
    // command bits
    localparam int CMD_WD_CLEAR = 0;
    localparam int CMD_SLEEP = 1;
    localparam int CMD_WAKE = 2;
    localparam int CMD_CLR_LOW = 3;
    localparam int CMD_CLR_HIGH = 4;
    // status bits
    localparam int ST_LOW_FLAG = 0;
    localparam int ST_HIGH_FLAG = 1;
    localparam int ST_PULSE = 2;
    localparam int ST_SLEEP = 3;
    localparam int ST_WD_RESET = 4;
    // resets
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] TIMER_CTRL_RESET = 8'h3F;
    // timing
    localparam int CLK_HZ = 40_000_000;
    localparam int WD_BASE_LONG_US = 18_000;
    localparam int WD_BASE_SHORT_US = 4_500;
    localparam int WD_LONG_CYC = (CLK_HZ / 1000) * WD_BASE_LONG_US / 1000;
    localparam int WD_SHORT_CYC = (CLK_HZ / 1000) * WD_BASE_SHORT_US / 1000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } twp_wr_s;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_LOW,
        PH_HIGH
    } twp_phase_e;
endpackage : twp_pkg

// ===== twp_timer.sv
module twp_timer #(
    parameter int WD_LONG = twp_pkg::WD_LONG_CYC,
    parameter int WD_SHORT = twp_pkg::WD_SHORT_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clock_div_option,
    input wire logic wd_short_option,
    input wire logic conversion_active,
    input wire logic conversion_wake_en,
    input wire logic wd_osc_tick,
    input wire logic timer_pin,
    output logic pulse_out_pin,
    output logic low_irq,
    output logic high_irq,
    output logic watchdog_reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import twp_pkg::*;

    function automatic logic [8:0] ratio_of(input logic en, input logic [2:0] sel);
        ratio_of = en ? (9'h002 << sel) : 9'h001;
    endfunction : ratio_of

    logic [7:0] lowTime, highTime, scaleCtrl, timerCtrl, carrierCnt, carrierCtrl, wdCtrl;
    logic [7:0] mainTimer, timerPre;
    logic lowFlag, highFlag, sleeping, wdCaused;
    twp_wr_s wr;
    logic awHeld, wHeld, wrFire, devRst;
    logic [1:0] wrResp;

    // write channel: address and data taken in either order
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign wrFire = awHeld && wHeld && !s_axi_bvalid;
    assign devRst = rst || watchdog_reset;
    always_ff @(posedge clk) begin
        if (rst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            wr <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                wr.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wr.data <= s_axi_wdata;
                wr.strb <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrResp;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wrB0;
    assign wrB0 = wrFire && wr.strb[0];
    always_comb begin
        case (wr.addr)
            OFF_LOW_TIME, OFF_HIGH_TIME, OFF_SCALE, OFF_PRESCALE, OFF_TIMER,
            OFF_TIMER_CTRL, OFF_CARRIER, OFF_CARRIER_CTRL, OFF_WDOG_CTRL,
            OFF_CMD: wrResp = RESP_OKAY;
            default: wrResp = RESP_SLVERR;
        endcase
    end
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit
    logic cmdClearWd, cmdSleep, cmdWake;
    assign cmdClearWd = wrB0 && hit(wr.addr, OFF_CMD) && wr.data[CMD_WD_CLEAR];
    assign cmdSleep = wrB0 && hit(wr.addr, OFF_CMD) && wr.data[CMD_SLEEP];
    assign cmdWake = wrB0 && hit(wr.addr, OFF_CMD) && wr.data[CMD_WAKE];

    always_ff @(posedge clk) begin
        if (devRst) begin
            lowTime <= CTRL_RESET;
            highTime <= CTRL_RESET;
            scaleCtrl <= CTRL_RESET;
            timerCtrl <= TIMER_CTRL_RESET;
            carrierCnt <= CTRL_RESET;
            carrierCtrl <= CTRL_RESET;
            wdCtrl <= CTRL_RESET;
        end else if (wrB0) begin
            if (hit(wr.addr, OFF_LOW_TIME)) lowTime <= wr.data[7:0];
            if (hit(wr.addr, OFF_HIGH_TIME)) highTime <= wr.data[7:0];
            if (hit(wr.addr, OFF_SCALE)) scaleCtrl <= wr.data[7:0];
            if (hit(wr.addr, OFF_TIMER_CTRL)) timerCtrl <= wr.data[7:0];
            if (hit(wr.addr, OFF_CARRIER)) carrierCnt <= wr.data[7:0];
            if (hit(wr.addr, OFF_CARRIER_CTRL)) carrierCtrl <= wr.data[7:0];
            if (hit(wr.addr, OFF_WDOG_CTRL)) wdCtrl <= wr.data[7:0];
        end
    end

    // read channel
    logic [7:0] status;
    assign status = {3'b000, wdCaused, sleeping, pulse_out_pin, highFlag, lowFlag};
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
                OFF_LOW_TIME: s_axi_rdata <= {24'h0000_00, lowTime};
                OFF_HIGH_TIME: s_axi_rdata <= {24'h0000_00, highTime};
                OFF_SCALE: s_axi_rdata <= {24'h0000_00, scaleCtrl};
                OFF_PRESCALE: s_axi_rdata <= {24'h0000_00, timerPre};
                OFF_TIMER: s_axi_rdata <= {24'h0000_00, mainTimer};
                OFF_TIMER_CTRL: s_axi_rdata <= {24'h0000_00, timerCtrl};
                OFF_CARRIER: s_axi_rdata <= {24'h0000_00, carrierCnt};
                OFF_CARRIER_CTRL: s_axi_rdata <= {24'h0000_00, carrierCtrl};
                OFF_WDOG_CTRL: s_axi_rdata <= {24'h0000_00, wdCtrl};
                OFF_CMD: s_axi_rdata <= 32'h0000_0000;
                OFF_STATUS: s_axi_rdata <= {24'h0000_00, status};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // tick and instruction-cycle strobes from the oscillator (clk)
    logic [1:0] divCnt;
    logic sysTick, instrTick;
    always_ff @(posedge clk) begin
        if (rst) divCnt <= 2'd0;
        else if (!sleeping || conversion_active) divCnt <= divCnt + 2'd1;
    end
    assign sysTick = clock_div_option ? divCnt[0] : 1'b1;
    assign instrTick = clock_div_option ? (divCnt == 2'd3) : divCnt[0];

    logic sleepRun;
    assign sleepRun = !sleeping || (conversion_active && conversion_wake_en);
    always_ff @(posedge clk) begin
        if (devRst) sleeping <= 1'b0;
        else if (cmdSleep) sleeping <= 1'b1;
        else if (cmdWake) sleeping <= 1'b0;
    end

    // timer pin: three stages, edge only when stages 2 and 3 agree on a change
    logic [2:0] pinSync;
    logic pinLevel, pinEdge;
    always_ff @(posedge clk) begin
        if (rst) begin
            pinSync <= 3'b000;
            pinLevel <= 1'b0;
        end else begin
            pinSync <= {pinSync[1:0], timer_pin};
            if (pinSync[2] == pinSync[1]) pinLevel <= pinSync[2];
        end
    end
    // edge bit 0 counts rising, 1 counts falling
    assign pinEdge = (pinSync[2] == pinSync[1]) && (pinSync[2] != pinLevel) &&
                     (pinSync[2] != timerCtrl[TMR_EDGE_BIT]);

    // main timer and its prescaler
    logic timerSrc, preOut, timerInc, preClr;
    logic [8:0] tmrRatio;
    assign timerSrc = timerCtrl[TMR_SRC_BIT] ? pinEdge : (instrTick && sleepRun);
    assign tmrRatio = ratio_of(1'b1, timerCtrl[TMR_RATIO_LSB +: 3]);
    assign preOut = (timerPre == 8'(tmrRatio - 9'd1));
    assign timerInc = timerSrc && (!timerCtrl[TMR_PRE_EN_BIT] || preOut);
    assign preClr = wrB0 && (hit(wr.addr, OFF_TIMER) || hit(wr.addr, OFF_TIMER_CTRL));
    always_ff @(posedge clk) begin
        if (devRst || preClr) timerPre <= 8'h00;
        else if (wrB0 && hit(wr.addr, OFF_PRESCALE)) timerPre <= wr.data[7:0];
        else if (timerSrc && timerCtrl[TMR_PRE_EN_BIT])
            timerPre <= preOut ? 8'h00 : timerPre + 8'h01;
    end
    always_ff @(posedge clk) begin
        if (devRst) mainTimer <= 8'h00;
        else if (wrB0 && hit(wr.addr, OFF_TIMER)) mainTimer <= wr.data[7:0];
        else if (timerInc) mainTimer <= mainTimer + 8'h01;
    end

    // watchdog on its own oscillator strobe, not gated by sleep
    logic [7:0] wdPre;
    logic [23:0] wdCnt;
    logic wdPreOut, wdStep, wdClr;
    logic [8:0] wdRatio;
    logic [23:0] wdLimit;
    assign wdClr = cmdClearWd || cmdSleep;
    assign wdRatio = ratio_of(wdCtrl[WD_PRE_EN_BIT], wdCtrl[WD_RATIO_LSB +: 3]);
    assign wdPreOut = (wdPre == 8'(wdRatio - 9'd1));
    assign wdStep = wd_osc_tick && wdCtrl[WD_EN_BIT] && wdPreOut;
    assign wdLimit = wd_short_option ? 24'(WD_SHORT - 1) : 24'(WD_LONG - 1);
    always_ff @(posedge clk) begin
        if (devRst || wdClr) begin
            wdPre <= 8'h00;
            wdCnt <= 24'h00_0000;
        end else if (wd_osc_tick && wdCtrl[WD_EN_BIT]) begin
            wdPre <= wdPreOut ? 8'h00 : wdPre + 8'h01;
            if (wdStep) wdCnt <= wdCnt + 24'h00_0001;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) watchdog_reset <= 1'b0;
        else watchdog_reset <= wdStep && (wdCnt == wdLimit) && !wdClr;
    end
    always_ff @(posedge clk) begin
        if (rst) wdCaused <= 1'b0;
        else if (watchdog_reset) wdCaused <= 1'b1;
    end

    // pulse generator
    twp_phase_e phase;
    logic [7:0] segCnt, carDiv;
    logic [8:0] segPre, lowRatio, highRatio, segRatio, carRatio;
    logic segStep, lowUnder, highUnder, carStep, carPhase;
    assign lowRatio = ratio_of(scaleCtrl[LOW_EN_BIT], scaleCtrl[LOW_SEL_LSB +: 3]);
    assign highRatio = ratio_of(scaleCtrl[HIGH_EN_BIT], scaleCtrl[HIGH_SEL_LSB +: 3]);
    assign segRatio = (phase == PH_LOW) ? lowRatio : highRatio;
    assign segStep = sysTick && sleepRun && (segPre == segRatio - 9'd1);
    assign lowUnder = segStep && (phase == PH_LOW) && (segCnt == 8'h00);
    assign highUnder = segStep && (phase == PH_HIGH) && (segCnt == 8'h00);
    always_ff @(posedge clk) begin
        if (devRst || !carrierCtrl[PULSE_EN_BIT]) begin
            phase <= PH_IDLE;
            segCnt <= 8'h00;
            segPre <= 9'h000;
        end else begin
            case (phase)
                PH_IDLE: begin
                    phase <= PH_LOW;
                    segCnt <= lowTime;
                    segPre <= 9'h000;
                end
                PH_LOW, PH_HIGH: begin
                    if (sysTick && sleepRun)
                        segPre <= segStep ? 9'h000 : segPre + 9'h001;
                    if (lowUnder) begin
                        phase <= PH_HIGH;
                        segCnt <= highTime;
                    end else if (highUnder) begin
                        phase <= PH_LOW;
                        segCnt <= lowTime;
                    end else if (segStep) begin
                        segCnt <= segCnt - 8'h01;
                    end
                end
                default: phase <= PH_IDLE;
            endcase
        end
    end

    // carrier toggles every (1+count)*ratio ticks
    logic [8:0] carPre;
    assign carRatio = ratio_of(carrierCtrl[CAR_PRE_EN_BIT], carrierCtrl[CAR_RATIO_LSB +: 3]);
    assign carStep = sysTick && sleepRun && (carPre == carRatio - 9'd1);
    always_ff @(posedge clk) begin
        if (devRst || !carrierCtrl[CARRIER_EN_BIT]) begin
            carPre <= 9'h000;
            carDiv <= 8'h00;
            carPhase <= 1'b0;
        end else if (sysTick && sleepRun) begin
            carPre <= carStep ? 9'h000 : carPre + 9'h001;
            if (carStep) begin
                if (carDiv == carrierCnt) begin
                    carDiv <= 8'h00;
                    carPhase <= !carPhase;
                end else begin
                    carDiv <= carDiv + 8'h01;
                end
            end
        end
    end

    // active level is low; carrier modulates the active segment
    always_ff @(posedge clk) begin
        if (devRst) pulse_out_pin <= 1'b1;
        else if (phase == PH_LOW)
            pulse_out_pin <= carrierCtrl[CARRIER_EN_BIT] ? carPhase : 1'b0;
        else pulse_out_pin <= 1'b1;
    end

    // flags: set wins over a clear in the same cycle
    logic clrLow, clrHigh;
    assign clrLow = wrB0 && hit(wr.addr, OFF_CMD) && wr.data[CMD_CLR_LOW];
    assign clrHigh = wrB0 && hit(wr.addr, OFF_CMD) && wr.data[CMD_CLR_HIGH];
    always_ff @(posedge clk) begin
        if (devRst) begin
            lowFlag <= 1'b0;
            highFlag <= 1'b0;
        end else begin
            if (lowUnder) lowFlag <= 1'b1;
            else if (clrLow) lowFlag <= 1'b0;
            if (highUnder) highFlag <= 1'b1;
            else if (clrHigh) highFlag <= 1'b0;
        end
    end
    assign low_irq = lowFlag && carrierCtrl[LOW_IE_BIT];
    assign high_irq = highFlag && carrierCtrl[HIGH_IE_BIT];

    a_low_sets_flag: assert property (@(posedge clk) disable iff (devRst)
        lowUnder |=> lowFlag && phase == PH_HIGH) else $error("low underflow lost");
    a_high_sets_flag: assert property (@(posedge clk) disable iff (devRst)
        highUnder |=> highFlag && phase == PH_LOW) else $error("high underflow lost");
    a_low_irq_gate: assert property (@(posedge clk) disable iff (devRst)
        lowUnder && carrierCtrl[LOW_IE_BIT] && !wrB0 |=> low_irq) else $error("no low irq");
    a_high_irq_gate: assert property (@(posedge clk) disable iff (devRst)
        highUnder && carrierCtrl[HIGH_IE_BIT] && !wrB0 |=> high_irq) else $error("no high irq");
    a_pre_clear: assert property (@(posedge clk) disable iff (rst)
        preClr |=> timerPre == 8'h00) else $error("prescaler not cleared");
    a_wd_clear: assert property (@(posedge clk) disable iff (rst)
        wdClr |=> wdCnt == 24'h00_0000 && wdPre == 8'h00) else $error("watchdog not cleared");
    a_timer_step: assert property (@(posedge clk) disable iff (devRst)
        timerInc && !preClr |=> mainTimer == $past(mainTimer) + 8'h01) else $error("timer missed");
    a_sleep_hold: assert property (@(posedge clk) disable iff (devRst)
        sleeping && !conversion_active && !timerCtrl[TMR_SRC_BIT] |-> !timerInc)
        else $error("timer ran in sleep");
    a_pulse_level: assert property (@(posedge clk) disable iff (devRst)
        phase == PH_HIGH |=> pulse_out_pin) else $error("pulse active in high time");
    c_low_under: cover property (@(posedge clk) lowUnder);
    c_high_under: cover property (@(posedge clk) highUnder);
    c_wd_reset: cover property (@(posedge clk) watchdog_reset);
endmodule : twp_timer
